// [rtl/lmp_map.svh]
/*
  Register offsets, field positions, reset values and timing counts of the lamp driver configuration port.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef LMP_MAP_SVH
`define LMP_MAP_SVH
`define LMP_REG_FIRST      4'h0
`define LMP_REG_SOUND      4'h5
`define LMP_REG_CH1        4'h6
`define LMP_REG_CH2        4'h7
`define LMP_REG_CH3        4'h8
`define LMP_REG_CH4        4'h9
`define LMP_REG_UPDATE     4'ha
`define LMP_REG_LAST       4'hb
`define LMP_CFG_RESET      8'h00
`define LMP_ADDR_PREFIX    5'h1e
`define LMP_BITS_PER_BYTE  4'h8
`define LMP_BIT_MOD        7
`define LMP_BIT_ENV        6
`define LMP_DIV_HI         5
`define LMP_DIV_LO         4
`define LMP_EN_HI          3
`define LMP_RT_HI          7
`define LMP_RT_LO          5
`define LMP_LVL_HI         4
`define LMP_DIV_CODE0      5'h10
`define LMP_DIV_CODE1      5'h08
`define LMP_DIV_CODE2      5'h04
`define LMP_DIV_CODE3      5'h02
`define LMP_RT_MUL1        32'h1
`define LMP_RT_MUL2        32'h2
`define LMP_RT_MUL3        32'h4
`define LMP_RT_MUL4        32'h8
`define LMP_RT_MUL5        32'hc
`define LMP_RT_MUL6        32'h10
`define LMP_RT_MUL7        32'h20
`define LMP_CLK_PERIOD_NS  8
`define LMP_RAMP_UNIT_NS   62500000
`define LMP_LEVEL_STEPS    31
`endif

// [rtl/lmp_pkg.sv]
/*
  Types of the lamp driver configuration port: the serial slave state encoding.
  Assumes nothing of its surroundings.
*/
package lmp_pkg;
  // Gray order along idle, address, ack, write, read, read ack, skip
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WDAT = 3'h2,
    ST_RDAT = 3'h6,
    ST_RACK = 3'h7,
    ST_SKIP = 3'h5
  } lmp_state_t;
endpackage

// [rtl/lmp_sync.sv]
/*
  Two-flop synchroniser for the serial pins and address-select pins.
  Assumes asynchronous inputs and the system clock and reset of the port.
*/
module lmp_sync
  import lmp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] asyncIn,
  output logic      [3:0] syncOut
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bit
      logic meta_q;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q     <= 1'b1;
          syncOut[i] <= 1'b1;
        end else begin
          meta_q     <= asyncIn[i];
          syncOut[i] <= meta_q;
        end
      end
    end
  endgenerate
endmodule // lmp_sync

// [rtl/lmp_lamp_cfg.sv]
/*
  Lamp control stage: sound-effect controls and per-channel ramped peak level.
  Assumes register values and a one-cycle update pulse from the serial port on the same clock.
*/
`include "lmp_map.svh"
module lmp_lamp_cfg
  import lmp_pkg::*;
#(
  parameter int unsigned STEP_CYC = 32'd1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  soundCfg,
  input  wire logic [31:0] chCfgFlat,
  input  wire logic        updateAll,
  output logic             modulationTypeSelect,
  output logic             envelopeFollow,
  output logic      [4:0]  soundFreqDivider,
  output logic      [3:0]  soundEffectEnable,
  output logic      [11:0] rampDurationSel,
  output logic      [19:0] peakLevelCode
);
  function automatic logic [31:0] rampMul(input logic [2:0] rt);
    case (rt)
      3'h1:    rampMul = `LMP_RT_MUL1;
      3'h2:    rampMul = `LMP_RT_MUL2;
      3'h3:    rampMul = `LMP_RT_MUL3;
      3'h4:    rampMul = `LMP_RT_MUL4;
      3'h5:    rampMul = `LMP_RT_MUL5;
      3'h6:    rampMul = `LMP_RT_MUL6;
      3'h7:    rampMul = `LMP_RT_MUL7;
      default: rampMul = 32'h0;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modulationTypeSelect <= 1'b0;
      envelopeFollow       <= 1'b0;
      soundFreqDivider     <= `LMP_DIV_CODE0;
      soundEffectEnable    <= 4'h0;
    end else begin
      modulationTypeSelect <= soundCfg[`LMP_BIT_MOD];
      envelopeFollow       <= soundCfg[`LMP_BIT_ENV] & ~soundCfg[`LMP_BIT_MOD];
      case (soundCfg[`LMP_DIV_HI:`LMP_DIV_LO])
        2'h0:    soundFreqDivider <= `LMP_DIV_CODE0;
        2'h1:    soundFreqDivider <= `LMP_DIV_CODE1;
        2'h2:    soundFreqDivider <= `LMP_DIV_CODE2;
        default: soundFreqDivider <= `LMP_DIV_CODE3;
      endcase
      // Frequency mode passes the effect only with every enable set
      soundEffectEnable <= soundCfg[`LMP_BIT_MOD] ? {4{&soundCfg[`LMP_EN_HI:0]}} : soundCfg[`LMP_EN_HI:0];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      logic [2:0]  rtAct_q;
      logic [4:0]  tgt_q;
      logic [4:0]  lvl_q;
      logic [31:0] cnt_q;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          rtAct_q <= 3'h0;
          tgt_q   <= 5'h00;
        end else if (updateAll) begin
          rtAct_q <= chCfgFlat[ch*8+`LMP_RT_LO +: 3];
          tgt_q   <= chCfgFlat[ch*8 +: 5];
        end
      end
      // Level walks one code per step; code 0 of the ramp field jumps at once
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl_q <= 5'h00;
          cnt_q <= 32'h0;
        end else if (lvl_q == tgt_q) begin
          cnt_q <= 32'h0;
        end else if (rtAct_q == 3'h0) begin
          lvl_q <= tgt_q;
        end else if (cnt_q >= STEP_CYC * rampMul(rtAct_q) - 32'h1) begin
          cnt_q <= 32'h0;
          lvl_q <= (lvl_q < tgt_q) ? lvl_q + 5'h01 : lvl_q - 5'h01;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end
      assign rampDurationSel[ch*3 +: 3] = rtAct_q;
      assign peakLevelCode[ch*5 +: 5]   = lvl_q;
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_fm_all_enable: assert property (modulationTypeSelect |-> (soundEffectEnable == 4'h0 || soundEffectEnable == 4'hf))
    else $error("partial enable in frequency mode");
  a_update_gate: assert property (!updateAll |=> $stable(rampDurationSel))
    else $error("ramp setting changed without update");
endmodule // lmp_lamp_cfg

// [rtl/lmp_i2c_cfg_port.sv]
/*
  Two-wire serial slave configuration port of a four-channel lamp driver, with its register file.
  Assumes a bus master driving the serial clock at up to 400 kHz, an external pull-up on the data line,
  and a system clock far faster than the serial clock.
*/
`include "lmp_map.svh"
// Operation
// - Mode bit picks amplitude or frequency modulation
// - Envelope bit tracks sound envelope, ignored in FM
// - Divider code selects sound divide by 16,8,4,2
// - Per-channel enables gate effect in AM
// - Ramp field chooses channel ramp duration
// - Level field scales channel amplitude linearly
// - Slave accepts master clock up to 400 kHz
// - Eight bit bytes each with acknowledge pulse
// - Data changes only with clock low
// - Start and stop detected while clock high
// - Repeated start keeps transaction alive
// - Stop aborts frame unless in start pulse
// - Address is prefix plus two select pins
// - Received bytes acknowledged over whole ninth pulse
// - Matching address acknowledged on ninth pulse
// - Write frame: address, pointer, data, stop
// - Data line open drain, never driven high
// - Pointer advances per write, sticks at last
// - Fresh read starts at zero, sticks at last
// - Preset pointer honoured across repeated start
// - Ramp and level apply on update command
module lmp_i2c_cfg_port
  import lmp_pkg::*;
#(
  parameter int unsigned RAMP_STEP_CYC = (`LMP_RAMP_UNIT_NS / `LMP_CLK_PERIOD_NS) / `LMP_LEVEL_STEPS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        addrSelectHi,
  input  wire logic        addrSelectLo,
  output logic             modulationTypeSelect,
  output logic             envelopeFollow,
  output logic      [4:0]  soundFreqDivider,
  output logic      [3:0]  soundEffectEnable,
  output logic      [11:0] rampDurationSel,
  output logic      [19:0] peakLevelCode
);
  logic       sclS;
  logic       sdaS;
  logic       aHiS;
  logic       aLoS;
  logic       sclP_q;
  logic       sdaP_q;
  logic       startHigh_q;
  lmp_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] txShift_q;
  logic       rwRead_q;
  logic       masterAck_q;
  logic       ptrPhase_q;
  logic       ptrPreset_q;
  logic [3:0] ptr_q;
  logic [7:0] soundCfg_q;
  logic [7:0] chCfg_q [0:3];
  logic       updStb_q;
  logic       sdaOe_q;
  logic       sdaOut_q;

  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic       stopOk;
  logic       byteDone;
  logic       addrHit;
  logic       wrEvt;
  logic       rdLoad;
  logic [3:0] ptrNext;
  logic [7:0] rdData;

  // Pins cross into the system clock; the fast sampling covers the shortest legal clock high time
  lmp_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({sclIn, sdaIn, addrSelectHi, addrSelectLo}),
    .syncOut ({sclS, sdaS, aHiS, aLoS})
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  assign sclRise  = sclS & ~sclP_q;
  assign sclFall  = ~sclS & sclP_q;
  // A data edge with the clock held high is a control condition, never data
  assign startDet = sclS & sclP_q & sdaP_q & ~sdaS;
  assign stopDet  = sclS & sclP_q & ~sdaP_q & sdaS;
  assign stopOk   = stopDet & ~startHigh_q;

  // Marks the clock-high pulse that carried a start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      startHigh_q <= 1'b0;
    end else if (startDet) begin
      startHigh_q <= 1'b1;
    end else if (sclFall) begin
      startHigh_q <= 1'b0;
    end
  end

  assign byteDone = sclFall & (bitCnt_q == `LMP_BITS_PER_BYTE);
  assign addrHit  = (shift_q[7:1] == {`LMP_ADDR_PREFIX, aHiS, aLoS});
  assign wrEvt    = (state_q == ST_WDAT) & byteDone;
  assign rdLoad   = sclFall & (((state_q == ST_AACK) & rwRead_q) | ((state_q == ST_RACK) & masterAck_q));
  assign ptrNext  = (ptr_q >= `LMP_REG_LAST) ? `LMP_REG_LAST : ptr_q + 4'h1;

  always_comb begin
    case (ptr_q)
      `LMP_REG_SOUND: rdData = soundCfg_q;
      `LMP_REG_CH1:   rdData = chCfg_q[0];
      `LMP_REG_CH2:   rdData = chCfg_q[1];
      `LMP_REG_CH3:   rdData = chCfg_q[2];
      `LMP_REG_CH4:   rdData = chCfg_q[3];
      default:        rdData = 8'h00;
    endcase
  end

  // Frame sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      bitCnt_q    <= 4'h0;
      rwRead_q    <= 1'b0;
      masterAck_q <= 1'b0;
    end else if (startDet) begin
      state_q  <= ST_ADDR;
      bitCnt_q <= 4'h0;
    end else if (stopOk) begin
      state_q  <= ST_IDLE;
      bitCnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteDone) begin
            bitCnt_q <= 4'h0;
            rwRead_q <= shift_q[0];
            state_q  <= addrHit ? ST_AACK : ST_SKIP;
          end
        end
        ST_WDAT: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteDone) begin
            bitCnt_q <= 4'h0;
            state_q  <= ST_AACK;
          end
        end
        ST_AACK: begin
          if (sclFall) begin
            bitCnt_q <= 4'h0;
            state_q  <= rwRead_q ? ST_RDAT : ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (sclFall) begin
            if (bitCnt_q == `LMP_BITS_PER_BYTE - 4'h1) begin
              bitCnt_q <= 4'h0;
              state_q  <= ST_RACK;
            end else begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            masterAck_q <= ~sdaS;
          end else if (sclFall) begin
            // A not-acknowledge ends the read; the bus is left to the master's stop
            state_q <= masterAck_q ? ST_RDAT : ST_SKIP;
          end
        end
        ST_IDLE, ST_SKIP: begin
          bitCnt_q <= 4'h0;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive shifter samples on the rising clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
    end else if (sclRise && (state_q == ST_ADDR || state_q == ST_WDAT)) begin
      shift_q <= {shift_q[6:0], sdaS};
    end
  end

  // Register pointer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q       <= `LMP_REG_FIRST;
      ptrPhase_q  <= 1'b0;
      ptrPreset_q <= 1'b0;
    end else if (stopOk) begin
      ptrPhase_q  <= 1'b0;
      ptrPreset_q <= 1'b0;
    end else if (state_q == ST_ADDR && byteDone && addrHit) begin
      if (shift_q[0]) begin
        ptrPreset_q <= 1'b0;
        if (!ptrPreset_q) begin
          ptr_q <= `LMP_REG_FIRST;
        end
      end else begin
        ptrPhase_q <= 1'b1;
      end
    end else if (wrEvt && ptrPhase_q) begin
      ptr_q       <= (shift_q > {4'h0, `LMP_REG_LAST}) ? `LMP_REG_LAST : shift_q[3:0];
      ptrPhase_q  <= 1'b0;
      ptrPreset_q <= 1'b1;
    end else if (wrEvt || rdLoad) begin
      ptr_q <= ptrNext;
    end
  end

  // Register file and update command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soundCfg_q <= `LMP_CFG_RESET;
      chCfg_q[0] <= `LMP_CFG_RESET;
      chCfg_q[1] <= `LMP_CFG_RESET;
      chCfg_q[2] <= `LMP_CFG_RESET;
      chCfg_q[3] <= `LMP_CFG_RESET;
      updStb_q   <= 1'b0;
    end else begin
      updStb_q <= 1'b0;
      if (wrEvt && !ptrPhase_q) begin
        case (ptr_q)
          `LMP_REG_SOUND:  soundCfg_q <= shift_q;
          `LMP_REG_CH1:    chCfg_q[0] <= shift_q;
          `LMP_REG_CH2:    chCfg_q[1] <= shift_q;
          `LMP_REG_CH3:    chCfg_q[2] <= shift_q;
          `LMP_REG_CH4:    chCfg_q[3] <= shift_q;
          `LMP_REG_UPDATE: updStb_q   <= 1'b1;
          default:         updStb_q   <= 1'b0;
        endcase
      end
    end
  end

  // Transmit shifter advances on the falling clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift_q <= 8'h00;
    end else if (rdLoad) begin
      txShift_q <= rdData;
    end else if (sclFall && state_q == ST_RDAT) begin
      txShift_q <= {txShift_q[6:0], 1'b0};
    end
  end

  // Open-drain data drive: the enable pulls low, the driven level stays low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOe_q  <= 1'b0;
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
      if (startDet || stopOk) begin
        sdaOe_q <= 1'b0;
      end else if (sclFall) begin
        case (state_q)
          ST_ADDR: sdaOe_q <= byteDone & addrHit;
          ST_WDAT: sdaOe_q <= byteDone;
          ST_AACK: sdaOe_q <= rwRead_q & ~rdData[7];
          ST_RDAT: sdaOe_q <= (bitCnt_q != `LMP_BITS_PER_BYTE - 4'h1) & ~txShift_q[6];
          ST_RACK: sdaOe_q <= masterAck_q & ~rdData[7];
          default: sdaOe_q <= 1'b0;
        endcase
      end
    end
  end

  assign sdaOe  = sdaOe_q;
  assign sdaOut = sdaOut_q;

  lmp_lamp_cfg #(
    .STEP_CYC (RAMP_STEP_CYC)
  ) u_lamp (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .soundCfg             (soundCfg_q),
    .chCfgFlat            ({chCfg_q[3], chCfg_q[2], chCfg_q[1], chCfg_q[0]}),
    .updateAll            (updStb_q),
    .modulationTypeSelect (modulationTypeSelect),
    .envelopeFollow       (envelopeFollow),
    .soundFreqDivider     (soundFreqDivider),
    .soundEffectEnable    (soundEffectEnable),
    .rampDurationSel      (rampDurationSel),
    .peakLevelCode        (peakLevelCode)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_hit;
    (state_q == ST_ADDR) && byteDone && addrHit;
  endsequence

  sequence s_ack_low;
    sdaOe_q && (state_q == ST_AACK);
  endsequence

  a_addr_ack: assert property (s_addr_hit |=> s_ack_low)
    else $error("matching address not acknowledged");
  a_ack_hold: assert property ((state_q == ST_AACK) && !sclFall && !startDet && !stopOk |=> sdaOe_q)
    else $error("acknowledge released inside ninth pulse");
  a_drive_window: assert property (sdaOe_q |-> state_q inside {ST_AACK, ST_RDAT})
    else $error("data line pulled outside ack or read");
  a_stop_abort: assert property (stopOk |=> (state_q == ST_IDLE) && !sdaOe_q)
    else $error("stop did not abort the frame");
  a_start_addr: assert property (startDet |=> (state_q == ST_ADDR) && (bitCnt_q == 4'h0))
    else $error("start did not open address phase");
  a_sr_keeps: assert property (startDet && (state_q != ST_IDLE) |=> ptrPreset_q == $past(ptrPreset_q))
    else $error("repeated start dropped the pointer preset");
  a_ptr_bound: assert property (ptr_q <= `LMP_REG_LAST)
    else $error("pointer beyond last register");
  a_ptr_advance: assert property (wrEvt && !ptrPhase_q && (ptr_q < `LMP_REG_LAST) |=> ptr_q == $past(ptr_q) + 4'h1)
    else $error("pointer did not advance after write");
  a_read_zero: assert property (s_addr_hit ##0 (shift_q[0] && !ptrPreset_q) |=> ptr_q == `LMP_REG_FIRST)
    else $error("fresh read did not start at zero");
  a_read_bit: assert property ((state_q == ST_RDAT) && sclRise |-> sdaOe_q == ~txShift_q[7])
    else $error("read bit not valid at rising clock");
  a_byte_ack: assert property ((state_q == ST_WDAT) && byteDone && !startDet && !stopOk |=> s_ack_low)
    else $error("received byte not followed by ack");
endmodule // lmp_i2c_cfg_port

// [verif/lmp_i2c_master.sv]
/*
  Behavioural two-wire bus master that drives the serial clock and pulls the data line low.
  Assumes a pull-up on the data line that the testbench resolves; paces itself by delays, free of the system clock.
*/
module lmp_i2c_master (
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Quarter of a 125 ns bit; each half still spans several system clocks of the port
  task automatic q();
    #31.25;
  endtask

  task automatic bitOut(input logic b);
    sdaLow <= ~b;
    q();
    scl <= 1'b1;
    q();
    q();
    scl <= 1'b0;
    q();
  endtask

  // Sampled twice while the clock is high: a low must stand the whole pulse
  task automatic bitIn(output logic b);
    logic s1;
    sdaLow <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    s1 = sdaWire;
    q();
    b = s1 | sdaWire;
    scl <= 1'b0;
    q();
  endtask

  // A start always ends with the clock low, so no stop follows it within its clock-high pulse
  task automatic start();
    sdaLow <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask

  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(n);
    ack = ~n;
  endtask

  // Acknowledge every byte but the last, which gets a not-acknowledge
  task automatic rdByte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(last);
  endtask
endmodule // lmp_i2c_master

// [verif/lmp_testbench.sv]
/*
  Self-checking testbench of the lamp driver configuration port.
  Assumes the behavioural bus master and a pull-up on the data line, modelled here.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 2;

  logic        sysClk;
  logic        rstN;
  logic        scl;
  logic        sdaLow;
  logic        sdaWire;
  logic        sdaOut;
  logic        sdaOe;
  logic        selHi;
  logic        selLo;
  logic        modSel;
  logic        envFol;
  logic [4:0]  divOut;
  logic [3:0]  enOut;
  logic [11:0] rampOut;
  logic [19:0] peakOut;
  logic [7:0]  devAddr = 8'hf4;
  logic [7:0]  regs [12] = '{default: 8'h00};
  int          badCount = 0;
  int          checkCount = 0;

  assign sdaWire = !(sdaLow || (sdaOe && !sdaOut));

  lmp_i2c_cfg_port #(.RAMP_STEP_CYC(STEP)) i_dut (
    .sys_clk(sysClk), .rst_n(rstN), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectHi(selHi), .addrSelectLo(selLo), .modulationTypeSelect(modSel), .envelopeFollow(envFol),
    .soundFreqDivider(divOut), .soundEffectEnable(enOut), .rampDurationSel(rampOut), .peakLevelCode(peakOut));

  lmp_i2c_master i_master (.sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

  initial begin
    sysClk = 1'b0;
    forever #4 sysClk = ~sysClk;
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The data pin may only ever pull low
  always @(negedge sysClk) begin
    if (sdaOe && sdaOut !== 1'b0) begin
      chk("sdaOut", 20'h0, {19'h0, sdaOut});
    end
  end

  task automatic wrRegs(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    i_master.start();
    i_master.wrByte(devAddr, a);
    chk("addr ack", 1'b1, a);
    i_master.wrByte(ptr, a);
    chk("ptr ack", 1'b1, a);
    foreach (d[i]) begin
      i_master.wrByte(d[i], a);
      chk("data ack", 1'b1, a);
      if (ptr + i >= 5 && ptr + i <= 9) regs[ptr + i] = d[i];
    end
    i_master.stop();
  endtask

  task automatic rdRegs(input int first, input int n, input logic preset);
    logic a;
    logic [7:0] d;
    i_master.start();
    if (preset) begin
      i_master.wrByte(devAddr, a);
      i_master.wrByte(8'(first), a);
      i_master.start();
    end
    i_master.wrByte(devAddr | 8'h01, a);
    chk("read ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      i_master.rdByte(i == n - 1, d);
      chk("read data", regs[(first + i > 11) ? 11 : first + i], d);
    end
    i_master.stop();
  endtask

  initial begin
    logic a;
    rstN = 1'b0;
    selHi = 1'b1;
    selLo = 1'b0;
    repeat (6) @(posedge sysClk);
    rstN <= 1'b1;
    repeat (125) @(posedge sysClk);
    chk("divider reset", 5'h10, divOut);
    for (int c = 0; c < 4; c++) begin
      wrRegs(8'h05, '{{1'b0, c[0], 2'(c), 4'ha}});
      repeat (4) @(posedge sysClk);
      chk("divider", 5'h10 >> c, divOut);
      chk("am enables", 4'ha, enOut);
      chk("envelope", c[0], envFol);
      chk("mod type", 1'b0, modSel);
    end
    wrRegs(8'h05, '{8'hca});
    repeat (4) @(posedge sysClk);
    chk("mod type", 1'b1, modSel);
    chk("envelope fm", 1'b0, envFol);
    chk("fm partial enables", 4'h0, enOut);
    wrRegs(8'h05, '{8'h8f});
    repeat (4) @(posedge sysClk);
    chk("fm enables", 4'hf, enOut);
    wrRegs(8'h06, '{8'h3f, 8'h07, 8'he1, 8'h50});
    repeat (300) @(posedge sysClk);
    chk("ramp before update", 12'h000, rampOut);
    chk("peak before update", 20'h0, peakOut);
    wrRegs(8'h0a, '{8'h00});
    chk("ch2 jump", 5'd7, peakOut[9:5]);
    chk("ch3 ramping", 5'd0, peakOut[14:10]);
    repeat (2000) @(posedge sysClk);
    chk("ramp", {3'd2, 3'd7, 3'd0, 3'd1}, rampOut);
    chk("peak", {5'd16, 5'd1, 5'd7, 5'd31}, peakOut);
    rdRegs(0, 14, 1'b0);
    rdRegs(7, 3, 1'b1);
    // Stop in the middle of a data byte abandons it
    i_master.start();
    i_master.wrByte(devAddr, a);
    i_master.wrByte(8'h05, a);
    for (int i = 0; i < 4; i++) i_master.bitOut(1'b0);
    i_master.stop();
    rdRegs(5, 1, 1'b1);
    i_master.start();
    i_master.wrByte(8'hf0, a);
    chk("foreign addr ack", 1'b0, a);
    i_master.stop();
    @(posedge sysClk);
    selLo <= 1'b1;
    devAddr = 8'hf6;
    repeat (10) @(posedge sysClk);
    rdRegs(6, 2, 1'b1);
    printVerdict();
  end

  initial begin
    repeat (80000) @(posedge sysClk);
    badCount++;
    $display("FAIL watchdog expected finish seen timeout");
    printVerdict();
  end
endmodule // testbench
